/* mclk_defs.svh */
// offsets, field positions, reset values and timing counts of the master clock block
`ifndef MCLK_DEFS_SVH
`define MCLK_DEFS_SVH

// system clock rate
`define CLK_MHZ 100
`define CLK_KHZ 100000

// oscillator supervision window, in microseconds
`define MON_WINDOW_US 100
// gross-error tolerance as a right shift of the expected count (1/8)
`define MON_TOL_SHIFT 3

// nco: 204.8 mhz master clock shown divided by 128 (1.6 mhz) on a 100 mhz clock
// increment = 1.6 / 100 * 2^40
`define NCO_NOM 40'd17592186044
// one trim step of about 2.5 ppb of the nominal increment
`define NCO_TRIM_STEP 40'd44

// oscillator rates per strap code, in khz
`define OSC_KHZ_000 32'd12800
`define OSC_KHZ_001 32'd25600
`define OSC_KHZ_010 32'd10000
`define OSC_KHZ_011 32'd20000
`define OSC_KHZ_100 32'd19440
`define OSC_KHZ_101 32'd38880
`define OSC_KHZ_110 32'd10240
`define OSC_KHZ_111 32'd20480

// register byte offsets
`define ADR_PART_LO 8'h00
`define ADR_PART_HI 8'h04
`define ADR_REV 8'h08
`define ADR_GUARD 8'h0c
`define ADR_TRIM 8'h10
`define ADR_LSR 8'h14
`define ADR_IEN 8'h18
`define ADR_STAT 8'h1c

// field positions
`define GUARD_BIT 0
`define FAIL_BIT 0
`define STAT_OK_BIT 0
`define STAT_RATE_LSB 1

// reset values
`define TRIM_RST 16'h0000
`define GUARD_RST 1'b0
`define IEN_RST 1'b0

`endif

/* mclk_pkg.sv */
// types shared by the master clock block
package mclk_pkg;

  // oscillator rate strap codes
  typedef enum logic [2:0] {
    RATE_12M8 = 3'b000,
    RATE_25M6 = 3'b001,
    RATE_10M = 3'b010,
    RATE_20M = 3'b011,
    RATE_19M44 = 3'b100,
    RATE_38M88 = 3'b101,
    RATE_10M24 = 3'b110,
    RATE_20M48 = 3'b111
  } rate_t;

  // expected oscillator edge count per window
  typedef logic [15:0] edge_count_t;

endpackage

/* osc_mon_if.sv */
// carrier between the master clock control and its oscillator monitor
`timescale 1ns/100ps
`default_nettype none
interface osc_mon_if;
  import mclk_pkg::*;
  edge_count_t expected; // edges expected per window
  logic fail; // one-cycle pulse: window judged bad
  logic ok; // level: last window judged good
  logic window_end; // one-cycle pulse at each window close

  modport mon (input expected, output fail, output ok, output window_end);
  modport ctrl (output expected, input fail, input ok, input window_end);
endinterface
`default_nettype wire

/* osc_monitor.sv */
// oscillator activity and gross frequency monitor
`timescale 1ns/100ps
`default_nettype none
`include "mclk_defs.svh"
module osc_monitor
  import mclk_pkg::*;
#(
  parameter int WINDOW_CYC = 10000 // window length in clock cycles
) (
  input wire logic clock, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic osc_in, // local oscillator, sampled
  osc_mon_if.mon mon // expected count in, verdicts out
);

  logic osc_prev_ff; // last sample of oscillator
  edge_count_t edges_ff; // rising edges seen this window
  logic [31:0] win_cnt_ff; // cycles into window
  logic fail_ff; // verdict pulse
  logic ok_ff; // good level
  logic end_ff; // window close pulse
  logic win_last; // last cycle of window
  logic rise; // rising edge of oscillator
  edge_count_t lo_lim; // low gross limit
  edge_count_t hi_lim; // high gross limit
  logic bad; // window verdict

  assign win_last = (win_cnt_ff == 32'(WINDOW_CYC - 1));
  assign rise = osc_in & ~osc_prev_ff;
  assign lo_lim = mon.expected - (mon.expected >> `MON_TOL_SHIFT);
  assign hi_lim = mon.expected + (mon.expected >> `MON_TOL_SHIFT);
  // a dead input counts zero edges and always fails
  assign bad = (edges_ff == 16'h0000) || (edges_ff < lo_lim) || (edges_ff > hi_lim);

  //////////////////////////////////////////////////////////////////////////////
  // edge sampling
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_prev_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_in;
    end
  end

  // window timer, free running so a stopped oscillator is still judged
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      win_cnt_ff <= 32'h0000_0000;
    end else if (win_last) begin
      win_cnt_ff <= 32'h0000_0000;
    end else begin
      win_cnt_ff <= win_cnt_ff + 32'h0000_0001;
    end
  end

  // edge counter, saturating so a wild input cannot wrap into range
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      edges_ff <= 16'h0000;
    end else if (win_last) begin
      edges_ff <= {15'h0000, rise};
    end else if (rise && edges_ff != 16'hffff) begin
      edges_ff <= edges_ff + 16'h0001;
    end
  end

  // verdict at window close
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fail_ff <= 1'b0;
      ok_ff <= 1'b0;
      end_ff <= 1'b0;
    end else begin
      fail_ff <= win_last & bad;
      end_ff <= win_last;
      if (win_last) begin
        ok_ff <= ~bad;
      end
    end
  end

  assign mon.fail = fail_ff;
  assign mon.ok = ok_ff;
  assign mon.window_end = end_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  dead_osc_a: assert property (@(posedge clock) disable iff (!arst_n)
    (win_last && edges_ff == 16'h0000) |=> (mon.fail && !mon.ok))
    else $error("dead oscillator window not flagged");

endmodule
`default_nettype wire

/* mclk_ctrl.sv */
// master clock synthesis, oscillator supervision, identity and write guard
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mclk_defs.svh"
module mclk_ctrl
  import mclk_pkg::*;
#(
  parameter logic [15:0] PART_CODE = 16'h5a3c, // arbitrary value
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter int MON_WINDOW_CYC = `MON_WINDOW_US * `CLK_MHZ // monitor window
) (
  input wire logic clock, // 100 mhz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic local_oscillator_input, // local oscillator, sampled
  input wire logic [2:0] osc_rate_select_pins, // rate strap
  output logic master_clock_out, // master clock divided by 128
  output logic interrupt_request_pin // interrupt, active high
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  osc_mon_if mon_bus (); // link to the monitor
  rate_t strap_ff; // captured strap
  logic strap_done_ff; // strap taken after reset release
  logic ack_ff; // wishbone ack
  logic [31:0] dat_ff; // wishbone read data
  logic guard_ff; // write guard engaged
  logic [15:0] trim_ff; // signed oscillator trim
  logic fail_flag_ff; // latched oscillator failure
  logic ien_ff; // failure interrupt enable
  logic irq_ff; // interrupt output
  logic [39:0] acc_ff; // nco phase
  logic mclk_ff; // master clock output
  logic req; // new request this cycle
  logic wr_now; // write takes effect this edge
  logic wr_open; // write allowed past the guard
  logic fail_clr; // software clears the flag
  logic [39:0] incr; // nco step with trim applied

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // expected oscillator edges per monitor window for a strap code
  function automatic edge_count_t expected_edges(input rate_t code);
    logic [31:0] khz;
    logic [31:0] prod;
    unique case (code)
      RATE_12M8: khz = `OSC_KHZ_000;
      RATE_25M6: khz = `OSC_KHZ_001;
      RATE_10M: khz = `OSC_KHZ_010;
      RATE_20M: khz = `OSC_KHZ_011;
      RATE_19M44: khz = `OSC_KHZ_100;
      RATE_38M88: khz = `OSC_KHZ_101;
      RATE_10M24: khz = `OSC_KHZ_110;
      RATE_20M48: khz = `OSC_KHZ_111;
    endcase
    // long windows would overflow 32 bits; keep the window near 100 us
    prod = khz * 32'(MON_WINDOW_CYC);
    expected_edges = 16'(prod / 32'(`CLK_KHZ));
  endfunction

  // byte-lane merge of write data into an 8-bit register
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                       input logic [31:0] din);
    lane0 = sel[0] ? din[7:0] : old;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // strap capture, taken once just after reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_ff <= RATE_12M8;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_ff <= rate_t'(osc_rate_select_pins);
      strap_done_ff <= 1'b1;
    end
  end

  // strap steers the monitor's frequency expectation
  assign mon_bus.expected = expected_edges(strap_ff);

  osc_monitor #(
    .WINDOW_CYC(MON_WINDOW_CYC)
  ) u_monitor (
    .clock(clock),
    .arst_n(arst_n),
    .osc_in(local_oscillator_input),
    .mon(mon_bus.mon)
  );

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // writes land on the edge where the master sees ack
  assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  // the guard register itself stays writable so it can be released
  assign wr_open = wr_now & ~guard_ff;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // read mux, registered; unmapped addresses read zero and still ack
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `ADR_PART_LO: dat_ff <= {24'h000000, PART_CODE[7:0]};
        `ADR_PART_HI: dat_ff <= {24'h000000, PART_CODE[15:8]};
        `ADR_REV: dat_ff <= {24'h000000, REVISION};
        `ADR_GUARD: dat_ff <= {31'h0000_0000, guard_ff};
        `ADR_TRIM: dat_ff <= {16'h0000, trim_ff};
        `ADR_LSR: dat_ff <= {31'h0000_0000, fail_flag_ff};
        `ADR_IEN: dat_ff <= {31'h0000_0000, ien_ff};
        `ADR_STAT: dat_ff <= {28'h0000000, strap_ff, mon_bus.ok};
        default: dat_ff <= 32'h0000_0000;
      endcase
    end else begin
      dat_ff <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write guard
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      guard_ff <= `GUARD_RST;
    end else if (wr_now && wb_adr_i == `ADR_GUARD && wb_sel_i[0]) begin
      guard_ff <= wb_dat_i[`GUARD_BIT];
    end
  end

  // oscillator trim, two byte lanes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trim_ff <= `TRIM_RST;
    end else if (wr_open && wb_adr_i == `ADR_TRIM) begin
      trim_ff <= {wb_sel_i[1] ? wb_dat_i[15:8] : trim_ff[15:8],
                  lane0(trim_ff[7:0], wb_sel_i, wb_dat_i)};
    end
  end

  // interrupt enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ien_ff <= `IEN_RST;
    end else if (wr_open && wb_adr_i == `ADR_IEN && wb_sel_i[0]) begin
      ien_ff <= wb_dat_i[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latched failure flag: write one to clear, a new failure wins
  assign fail_clr = wr_open && wb_adr_i == `ADR_LSR && wb_sel_i[0] && wb_dat_i[`FAIL_BIT];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fail_flag_ff <= 1'b0;
    end else if (mon_bus.fail) begin
      fail_flag_ff <= 1'b1;
    end else if (fail_clr) begin
      fail_flag_ff <= 1'b0;
    end
  end

  // interrupt follows the enabled flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= fail_flag_ff & ien_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master clock nco; free running, so it never stops with the oscillator
  assign incr = `NCO_NOM + {{24{trim_ff[15]}}, trim_ff} * `NCO_TRIM_STEP;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= 40'h00_0000_0000;
      mclk_ff <= 1'b0;
    end else begin
      acc_ff <= acc_ff + incr;
      mclk_ff <= acc_ff[39];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign master_clock_out = mclk_ff;
  assign interrupt_request_pin = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // identity reads answer one cycle after the request
  id_low_read_a: assert property (
    (req && !wb_we_i && wb_adr_i == `ADR_PART_LO)
      |=> (wb_ack_o && wb_dat_o[7:0] == PART_CODE[7:0]))
    else $error("part code low byte wrong");

  // the high half of the part code must match too
  id_high_read_a: assert property (
    (req && !wb_we_i && wb_adr_i == `ADR_PART_HI)
      |=> (wb_ack_o && wb_dat_o[7:0] == PART_CODE[15:8]))
    else $error("part code high byte wrong");

  // revision is a fixed parameter, never a register
  rev_read_a: assert property (
    (req && !wb_we_i && wb_adr_i == `ADR_REV) |=> (wb_ack_o && wb_dat_o == {24'h000000, REVISION}))
    else $error("revision read wrong");

  guard_block_a: assert property (
    (wr_now && guard_ff && wb_adr_i == `ADR_TRIM) |=> $stable(trim_ff))
    else $error("trim written while guarded");

  // the release edge is skipped: the flops still see reset on it
  nco_step_a: assert property (
    arst_n |=> (acc_ff == $past(acc_ff) + `NCO_NOM + {{24{$past(trim_ff[15])}}, $past(trim_ff)}
              * `NCO_TRIM_STEP))
    else $error("nco step does not follow trim");

  mclk_toggle_a: assert property (
    1'b1 |-> ##[1:40] (master_clock_out != $past(master_clock_out)))
    else $error("master clock stopped");

  fail_set_a: assert property (
    mon_bus.fail |=> fail_flag_ff)
    else $error("failure not latched");

  irq_follow_a: assert property (
    (fail_flag_ff && ien_ff) |=> interrupt_request_pin)
    else $error("interrupt not raised");

  strap_decode_a: assert property (
    (strap_done_ff && strap_ff == RATE_38M88) |-> (mon_bus.expected ==
      16'((`OSC_KHZ_101 * 32'(MON_WINDOW_CYC)) / 32'(`CLK_KHZ))))
    else $error("strap rate decode wrong");

  flag_hold_a: assert property (
    (fail_flag_ff && !fail_clr) |=> fail_flag_ff)
    else $error("failure flag dropped without clear");

  // a clear with no fresh failure drops the flag
  flag_clear_a: assert property (
    (fail_clr && !mon_bus.fail) |=> !fail_flag_ff)
    else $error("failure flag not cleared");

  // interrupt enable ignores writes while the guard is engaged
  guard_ien_a: assert property (
    (wr_now && guard_ff && wb_adr_i == `ADR_IEN) |=> $stable(ien_ff))
    else $error("interrupt enable written while guarded");

  // an open trim write lands in full on the acked edge
  trim_write_a: assert property (
    (wr_open && wb_adr_i == `ADR_TRIM && wb_sel_i[1:0] == 2'b11)
      |=> (trim_ff == $past(wb_dat_i[15:0])))
    else $error("open trim write did not land");

  // a failure verdict only ever comes at a window close
  verdict_close_a: assert property (
    mon_bus.fail |-> mon_bus.window_end)
    else $error("failure verdict outside window close");

  // with the source masked the pin stays low
  irq_mask_a: assert property (
    !ien_ff |=> !interrupt_request_pin)
    else $error("interrupt raised while masked");

  // the strap is taken once and then held until the next reset
  strap_hold_a: assert property (
    strap_done_ff |=> $stable(strap_ff))
    else $error("strap changed after capture");

endmodule
`default_nettype wire

/* osc_model.sv */
// behavioural local oscillator that feeds the master clock block
`timescale 1ns/100ps
`default_nettype none
module osc_model (
  input wire logic run, // 1 = oscillating, 0 = stopped
  input wire logic [2:0] rate, // frequency code of the fitted part
  output logic osc // oscillator output
);
  ////////////////////////////////////////////////////////////////
  // half period in ns per frequency code; board fits what it straps
  function automatic real half_ns(input logic [2:0] r);
    case (r)
      3'h0: return 39.0625;
      3'h1: return 19.53125;
      3'h2: return 50.0;
      3'h3: return 25.0;
      3'h4: return 25.72;
      3'h5: return 12.86;
      3'h6: return 48.828125;
      default: return 24.4140625;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // a dead oscillator rests low rather than freezing mid-swing
  initial osc = 1'b0;
  always begin
    if (run === 1'b1) begin
      #(half_ns(rate)) osc = ~osc;
    end else begin
      osc = 1'b0;
      @(posedge run);
    end
  end
endmodule
`default_nettype wire

/* master_clock_id_protect_bench.sv */
// self-checking bench for master clock, identity and write guard
`timescale 1ns/100ps
`default_nettype none
`include "mclk_defs.svh"
module master_clock_id_protect_bench;
  import mclk_pkg::*;
  localparam int WIN = 1000; // short monitor window keeps the run brief
  localparam logic [15:0] PART = 16'h1e2d; // arbitrary value
  localparam logic [7:0] REV = 8'h03; // arbitrary value
  logic clock, arst_n, cyc, stb, we, ack, osc_line, mclk, irq, osc_run, prev;
  logic [7:0] adr; // bus address
  logic [3:0] sel; // byte lanes
  logic [31:0] wdat, rdat, q; // write data, read data, last read
  logic [2:0] strap, osc_rate; // strap pins, fitted oscillator code
  int fails, checked, n_tog;

  mclk_ctrl #(.PART_CODE(PART), .REVISION(REV), .MON_WINDOW_CYC(WIN)) dut_u (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .local_oscillator_input(osc_line), .osc_rate_select_pins(strap),
    .master_clock_out(mclk), .interrupt_request_pin(irq));
  osc_model osc_u (.run(osc_run), .rate(osc_rate), .osc(osc_line));

  ////////////////////////////////////////////////////////////////
  // 100 mhz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////
  // verdict and compare helpers
  task automatic end_of_test;
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    wb(a, 1'b0, 32'h0);
    chk(name, q, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // reset held long enough for two slow oscillator cycles
  task automatic rst(input logic [2:0] code);
    @(posedge clock);
    strap <= code;
    arst_n <= 1'b0;
    wait_cyc(25);
    arst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    wait_cyc(60000);
    fails++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat, strap, osc_rate} = '0;
    sel = 4'hf;
    osc_run = 1'b1;
    arst_n = 1'b0;
    fails = 0;
    checked = 0;
    wait_cyc(5);
    arst_n <= 1'b1;
    // reset values and an unmapped place
    rd(`ADR_PART_LO, {24'h0, PART[7:0]}, "part_lo");
    rd(`ADR_PART_HI, {24'h0, PART[15:8]}, "part_hi");
    rd(`ADR_REV, {24'h0, REV}, "rev");
    rd(`ADR_GUARD, 32'h0, "guard");
    rd(`ADR_TRIM, 32'h0, "trim");
    rd(`ADR_LSR, 32'h0, "lsr");
    rd(`ADR_IEN, 32'h0, "ien");
    rd(8'h20, 32'h0, "unmapped");
    // read-only places shrug off writes
    wb(`ADR_PART_LO, 1'b1, 32'hffff_ffff);
    wb(`ADR_PART_HI, 1'b1, 32'hffff_ffff);
    wb(`ADR_REV, 1'b1, 32'hffff_ffff);
    rd(`ADR_PART_LO, {24'h0, PART[7:0]}, "part_lo_ro");
    rd(`ADR_PART_HI, {24'h0, PART[15:8]}, "part_hi_ro");
    rd(`ADR_REV, {24'h0, REV}, "rev_ro");
    // trim, then the guard blocking it
    wb(`ADR_TRIM, 1'b1, 32'h0000_8001);
    rd(`ADR_TRIM, 32'h0000_8001, "trim_rw");
    wb(`ADR_GUARD, 1'b1, 32'h1);
    wb(`ADR_TRIM, 1'b1, 32'h0000_1234);
    wb(`ADR_IEN, 1'b1, 32'h1);
    rd(`ADR_TRIM, 32'h0000_8001, "trim_guarded");
    rd(`ADR_IEN, 32'h0, "ien_guarded");
    rd(`ADR_GUARD, 32'h1, "guard_on");
    wb(`ADR_GUARD, 1'b1, 32'h0);
    wb(`ADR_TRIM, 1'b1, 32'h0);
    rd(`ADR_TRIM, 32'h0, "trim_unguarded");
    // each strap code with a matching oscillator passes supervision
    for (int c = 0; c < 8; c++) begin
      osc_rate <= 3'(c);
      rst(3'(c));
      wait_cyc(WIN + 100);
      rd(`ADR_STAT, {28'h0, 3'(c), 1'b1}, "status");
      rd(`ADR_LSR, 32'h0, "lsr_good");
    end
    // master clock keeps running, 20 transitions per 625 cycles
    osc_run <= 1'b0;
    n_tog = 0;
    prev = mclk;
    repeat (625) begin
      @(negedge clock);
      if (mclk !== prev) n_tog++;
      prev = mclk;
    end
    chk("mclk_toggles", 32'(n_tog >= 19 && n_tog <= 21), 32'h1);
    // stopped oscillator latches the flag and raises the interrupt
    wb(`ADR_IEN, 1'b1, 32'h1);
    wait_cyc(2 * WIN + 50);
    rd(`ADR_LSR, 32'h1, "lsr_stopped");
    chk("irq_on", {31'h0, irq}, 32'h1);
    // flag sticks after recovery until cleared
    osc_run <= 1'b1;
    wait_cyc(2 * WIN);
    rd(`ADR_STAT, {28'h0, 3'h7, 1'b1}, "status_back");
    rd(`ADR_LSR, 32'h1, "lsr_sticky");
    wb(`ADR_LSR, 1'b1, 32'h1);
    rd(`ADR_LSR, 32'h0, "lsr_cleared");
    wait_cyc(3);
    chk("irq_off", {31'h0, irq}, 32'h0);
    // twice the strapped rate is grossly off; interrupt masked
    osc_rate <= 3'h1;
    rst(3'h0);
    wait_cyc(WIN + 100);
    rd(`ADR_LSR, 32'h1, "lsr_gross");
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wb(`ADR_IEN, 1'b1, 32'h1);
    wait_cyc(3);
    chk("irq_enabled", {31'h0, irq}, 32'h1);
    wb(`ADR_TRIM, 1'b1, 32'h0000_0010);
    // asynchronous reset in mid-run
    @(posedge clock);
    arst_n <= 1'b0;
    @(negedge clock);
    chk("irq_in_reset", {31'h0, irq}, 32'h0);
    chk("mclk_in_reset", {31'h0, mclk}, 32'h0);
    wait_cyc(25);
    arst_n <= 1'b1;
    rd(`ADR_TRIM, 32'h0, "trim_after_reset");
    rd(`ADR_LSR, 32'h0, "lsr_after_reset");
    end_of_test();
  end
endmodule
`default_nettype wire
